// ===== hdl/clock_gate_pkg.sv
// Behaviour
// - each writable bit of the deep-sleep gating register is the clock enable of exactly one unit.
// - a set gating bit delivers a clock to its unit so that the unit runs.
// - a clear gating bit stops the unit clock and holds the unit disabled.
// - an access aimed at a unit whose clock is off is answered with a bus fault.
// - reset clears the register to zero so every unit starts unclocked; writable bits are read/write.
// - the deep-sleep gating register decodes at offset 0x124 from the system control base.
// - run, sleep and deep-sleep gating registers exist in parallel for the same units.
// - sleep and deep-sleep gating apply only while the automatic gating bit is set.
// - bit 24 gates analog comparator 0.
// - bit 18 gates general-purpose timer 2.
// - bit 17 gates general-purpose timer 1.
// - bit 16 gates general-purpose timer 0.
// - bit 12 gates two-wire serial module 0.
// - bit 4 gates synchronous serial module 0.
// - bit 1 gates asynchronous serial module 1 and bit 0 asynchronous serial module 0.
package clock_gate_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [31:0] SYS_CTRL_BASE          = 32'h400f_e000;
    localparam logic [11:0] RUN_CLOCK_CONFIG_OFS   = 12'h060;
    localparam logic [11:0] RUN_CLOCK_GATE_1_OFS   = 12'h104;
    localparam logic [11:0] SLEEP_CLOCK_GATE_1_OFS = 12'h114;
    localparam logic [11:0] DEEP_CLOCK_GATE_1_OFS  = 12'h124;
    localparam logic [11:0] IRQ_STATUS_OFS         = 12'h200;
    localparam logic [11:0] IRQ_MASK_OFS           = 12'h204;
    localparam logic [11:0] FAULT_UNIT_OFS         = 12'h208;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          COMPARATOR_BIT   = 24;
    localparam int          GP_TIMER_2_BIT   = 18;
    localparam int          GP_TIMER_1_BIT   = 17;
    localparam int          GP_TIMER_0_BIT   = 16;
    localparam int          TWO_WIRE_BIT     = 12;
    localparam int          SYNC_SERIAL_BIT  = 4;
    localparam int          ASYNC_1_BIT      = 1;
    localparam int          ASYNC_0_BIT      = 0;
    localparam int          AUTO_GATE_BIT    = 27;
    localparam int          FAULT_EVENT_BIT  = 0;
    localparam int          DEEP_EVENT_BIT   = 1;
    localparam logic [31:0] GATE_WRITE_MASK  = 32'h0107_1013;
    localparam logic [31:0] GATE_RESET       = 32'h0000_0000;
    localparam logic        AUTO_GATE_RESET  = 1'h0;
    localparam logic [1:0]  IRQ_RESET        = 2'h0;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic comparator_gate;
        logic gp_timer_2_gate;
        logic gp_timer_1_gate;
        logic gp_timer_0_gate;
        logic two_wire_port_gate;
        logic sync_serial_port_gate;
        logic async_serial_1_gate;
        logic async_serial_0_gate;
    } unit_gates_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

// ===== hdl/deep_sleep_clock_gating_one.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module deep_sleep_clock_gating_one
    import clock_gate_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register port
    input  wire reg_req_t    reg_req,
    output logic [31:0]      rdata,
    // power mode from the power controller
    input  wire logic        sleep_mode,
    input  wire logic        deep_sleep_mode,
    // peripheral access check
    input  wire logic        periph_req,
    input  wire unit_gates_t periph_sel,
    output logic             periph_ack,
    output logic             bus_fault,
    // unit clock enables
    output unit_gates_t      unit_en,
    // interrupt
    output logic             irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] run_clock_gate_1;
        logic [31:0] sleep_clock_gate_1;
        logic [31:0] deep_sleep_clock_gate_1;
        logic        auto_gate_select;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        unit_gates_t fault_unit;
        unit_gates_t unit_en;
        logic        in_deep;
        logic [31:0] rdata;
        logic        periph_ack;
        logic        bus_fault;
        logic        irq;
    } state_t;

    state_t st;
    state_t next_st;

    // ****************************************
    // helpers
    // ****************************************
    function automatic unit_gates_t gates_of(input logic [31:0] r);
        unit_gates_t g;
        g.comparator_gate       = r[COMPARATOR_BIT];
        g.gp_timer_2_gate       = r[GP_TIMER_2_BIT];
        g.gp_timer_1_gate       = r[GP_TIMER_1_BIT];
        g.gp_timer_0_gate       = r[GP_TIMER_0_BIT];
        g.two_wire_port_gate    = r[TWO_WIRE_BIT];
        g.sync_serial_port_gate = r[SYNC_SERIAL_BIT];
        g.async_serial_1_gate   = r[ASYNC_1_BIT];
        g.async_serial_0_gate   = r[ASYNC_0_BIT];
        return g;
    endfunction

    function automatic logic [31:0] widen(input logic [1:0] v);
        return {30'h0000_0000, v};
    endfunction

    function automatic logic [31:0] widen_gates(input unit_gates_t g);
        return {24'h00_0000, g};
    endfunction

    // ****************************************
    // next state
    // ****************************************
    logic        fault_now;
    logic        deep_entry;
    logic [31:0] gate_wdata;
    logic [1:0]  event_set;
    logic [1:0]  status_clr;

    always_comb
    begin
        next_st    = st;
        gate_wdata = reg_req.wdata & GATE_WRITE_MASK;
        fault_now  = periph_req && ((periph_sel & ~st.unit_en) != '0);
        deep_entry = st.auto_gate_select && deep_sleep_mode && !st.in_deep;
        event_set  = '0;
        status_clr = '0;
        event_set[FAULT_EVENT_BIT] = fault_now;
        event_set[DEEP_EVENT_BIT]  = deep_entry;

        // register writes
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                RUN_CLOCK_CONFIG_OFS:
                    next_st.auto_gate_select = reg_req.wdata[AUTO_GATE_BIT];
                RUN_CLOCK_GATE_1_OFS:
                    next_st.run_clock_gate_1 = gate_wdata;
                SLEEP_CLOCK_GATE_1_OFS:
                    next_st.sleep_clock_gate_1 = gate_wdata;
                DEEP_CLOCK_GATE_1_OFS:
                    next_st.deep_sleep_clock_gate_1 = gate_wdata;
                IRQ_STATUS_OFS:
                    status_clr = reg_req.wdata[1:0];
                IRQ_MASK_OFS:
                    next_st.irq_mask = reg_req.wdata[1:0];
                default:
                    next_st.irq_mask = st.irq_mask;
            endcase
        end

        // sticky events, a set wins over a clear
        next_st.irq_status = (st.irq_status & ~status_clr) | event_set;
        next_st.irq        = (next_st.irq_status & next_st.irq_mask) != '0;

        // register reads, data stand one cycle later
        next_st.rdata = '0;
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                RUN_CLOCK_CONFIG_OFS:
                    next_st.rdata[AUTO_GATE_BIT] = st.auto_gate_select;
                RUN_CLOCK_GATE_1_OFS:
                    next_st.rdata = st.run_clock_gate_1;
                SLEEP_CLOCK_GATE_1_OFS:
                    next_st.rdata = st.sleep_clock_gate_1;
                DEEP_CLOCK_GATE_1_OFS:
                    next_st.rdata = st.deep_sleep_clock_gate_1;
                IRQ_STATUS_OFS:
                    next_st.rdata = widen(st.irq_status);
                IRQ_MASK_OFS:
                    next_st.rdata = widen(st.irq_mask);
                FAULT_UNIT_OFS:
                    next_st.rdata = widen_gates(st.fault_unit);
                default:
                    next_st.rdata = '0;
            endcase
        end

        // effective unit enables by power mode
        if (!st.auto_gate_select)
            next_st.unit_en = gates_of(st.run_clock_gate_1);
        else if (deep_sleep_mode)
            next_st.unit_en = gates_of(st.deep_sleep_clock_gate_1);
        else if (sleep_mode)
            next_st.unit_en = gates_of(st.sleep_clock_gate_1);
        else
            next_st.unit_en = gates_of(st.run_clock_gate_1);
        next_st.in_deep = st.auto_gate_select && deep_sleep_mode;

        // access answer: fault for an unclocked unit, else acknowledge
        next_st.bus_fault  = fault_now;
        next_st.periph_ack = periph_req && !fault_now;
        if (fault_now)
            next_st.fault_unit = periph_sel & ~st.unit_en;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st                         <= '0;
            st.run_clock_gate_1        <= GATE_RESET;
            st.sleep_clock_gate_1      <= GATE_RESET;
            st.deep_sleep_clock_gate_1 <= GATE_RESET;
            st.auto_gate_select        <= AUTO_GATE_RESET;
            st.irq_status              <= IRQ_RESET;
            st.irq_mask                <= IRQ_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata      = st.rdata;
    assign periph_ack = st.periph_ack;
    assign bus_fault  = st.bus_fault;
    assign unit_en    = st.unit_en;
    assign irq        = st.irq;

    // ****************************************
    // checks
    // ****************************************
    property p_reset_clear;
        @(posedge sys_clk) $fell(rst) |-> (st.deep_sleep_clock_gate_1 == '0) && (unit_en == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("gating not cleared by reset");

    property p_deep_write;
        @(posedge sys_clk) disable iff (rst)
        reg_req.wr && reg_req.addr == DEEP_CLOCK_GATE_1_OFS
        |=> st.deep_sleep_clock_gate_1 == ($past(reg_req.wdata) & GATE_WRITE_MASK);
    endproperty
    a_deep_write: assert property (p_deep_write) else $error("deep-sleep write not stored");

    property p_deep_read;
        @(posedge sys_clk) disable iff (rst)
        reg_req.rd && reg_req.addr == DEEP_CLOCK_GATE_1_OFS && !reg_req.wr
        |=> rdata == $past(st.deep_sleep_clock_gate_1) && (rdata & ~GATE_WRITE_MASK) == '0;
    endproperty
    a_deep_read: assert property (p_deep_read) else $error("deep-sleep read wrong");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (rst)
        (st.deep_sleep_clock_gate_1 & ~GATE_WRITE_MASK) == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved gating bit set");

    property p_run_write;
        @(posedge sys_clk) disable iff (rst)
        reg_req.wr && reg_req.addr == RUN_CLOCK_GATE_1_OFS
        |=> st.run_clock_gate_1 == ($past(reg_req.wdata) & GATE_WRITE_MASK);
    endproperty
    a_run_write: assert property (p_run_write) else $error("run gating write not stored");

    property p_sleep_write;
        @(posedge sys_clk) disable iff (rst)
        reg_req.wr && reg_req.addr == SLEEP_CLOCK_GATE_1_OFS
        |=> st.sleep_clock_gate_1 == ($past(reg_req.wdata) & GATE_WRITE_MASK);
    endproperty
    a_sleep_write: assert property (p_sleep_write) else $error("sleep gating write not stored");

    property p_read_idle;
        @(posedge sys_clk) disable iff (rst)
        !reg_req.rd |=> rdata == '0;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside a read");

    property p_fault;
        @(posedge sys_clk) disable iff (rst)
        periph_req && ((periph_sel & ~unit_en) != '0) |=> bus_fault && !periph_ack;
    endproperty
    a_fault: assert property (p_fault) else $error("access to unclocked unit not faulted");

    property p_no_fault;
        @(posedge sys_clk) disable iff (rst)
        periph_req && ((periph_sel & ~unit_en) == '0) |=> periph_ack && !bus_fault;
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("access to clocked unit faulted");

    property p_idle_quiet;
        @(posedge sys_clk) disable iff (rst)
        !periph_req |=> !bus_fault && !periph_ack;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("answer without access");

    property p_fault_unit;
        @(posedge sys_clk) disable iff (rst)
        periph_req && ((periph_sel & ~unit_en) != '0)
        |=> st.fault_unit == $past(periph_sel & ~unit_en);
    endproperty
    a_fault_unit: assert property (p_fault_unit) else $error("faulting unit not recorded");

    property p_fault_sets_status;
        @(posedge sys_clk) disable iff (rst)
        periph_req && ((periph_sel & ~unit_en) != '0) |=> st.irq_status[FAULT_EVENT_BIT];
    endproperty
    a_fault_sets_status: assert property (p_fault_sets_status) else $error("fault event not flagged");

    property p_fault_sticky;
        @(posedge sys_clk) disable iff (rst)
        st.irq_status[FAULT_EVENT_BIT]
        && !(reg_req.wr && reg_req.addr == IRQ_STATUS_OFS && reg_req.wdata[FAULT_EVENT_BIT])
        |=> st.irq_status[FAULT_EVENT_BIT];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag lost");

    property p_set_wins;
        @(posedge sys_clk) disable iff (rst)
        periph_req && ((periph_sel & ~unit_en) != '0) && reg_req.wr && reg_req.addr == IRQ_STATUS_OFS
        |=> st.irq_status[FAULT_EVENT_BIT] ##1 1'b1;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("fault event lost to clear");

    property p_irq_level;
        @(posedge sys_clk) disable iff (rst)
        irq == ((st.irq_status & st.irq_mask) != '0);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_run_only;
        @(posedge sys_clk) disable iff (rst)
        !st.auto_gate_select ##1 !$past(st.auto_gate_select)
        |-> unit_en == gates_of($past(st.run_clock_gate_1));
    endproperty
    a_run_only: assert property (p_run_only) else $error("sleep gating used without auto gating");

    property p_deep_select;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && deep_sleep_mode
        |=> unit_en == gates_of($past(st.deep_sleep_clock_gate_1));
    endproperty
    a_deep_select: assert property (p_deep_select) else $error("deep-sleep enables not applied");

    property p_sleep_select;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && sleep_mode && !deep_sleep_mode
        |=> unit_en == gates_of($past(st.sleep_clock_gate_1));
    endproperty
    a_sleep_select: assert property (p_sleep_select) else $error("sleep enables not applied");

    property p_run_select;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && !sleep_mode && !deep_sleep_mode
        |=> unit_en == gates_of($past(st.run_clock_gate_1));
    endproperty
    a_run_select: assert property (p_run_select) else $error("run enables not applied");

    property p_deep_entry;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && deep_sleep_mode && !st.in_deep
        |=> st.irq_status[DEEP_EVENT_BIT];
    endproperty
    a_deep_entry: assert property (p_deep_entry) else $error("deep-sleep entry not flagged");

    property p_comparator_off;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && deep_sleep_mode && !st.deep_sleep_clock_gate_1[COMPARATOR_BIT]
        |=> !unit_en.comparator_gate;
    endproperty
    a_comparator_off: assert property (p_comparator_off) else $error("comparator clocked while gated");

    property p_gate_on;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && deep_sleep_mode && st.deep_sleep_clock_gate_1[COMPARATOR_BIT]
        |=> unit_en.comparator_gate;
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("comparator not clocked while enabled");

    property p_timer_bits;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && deep_sleep_mode
        |=> {unit_en.gp_timer_2_gate, unit_en.gp_timer_1_gate, unit_en.gp_timer_0_gate}
            == $past(st.deep_sleep_clock_gate_1[GP_TIMER_2_BIT:GP_TIMER_0_BIT]);
    endproperty
    a_timer_bits: assert property (p_timer_bits) else $error("timer enables misplaced");

    property p_serial_bits;
        @(posedge sys_clk) disable iff (rst)
        st.auto_gate_select && deep_sleep_mode
        |=> unit_en.two_wire_port_gate == $past(st.deep_sleep_clock_gate_1[TWO_WIRE_BIT])
            && unit_en.sync_serial_port_gate == $past(st.deep_sleep_clock_gate_1[SYNC_SERIAL_BIT])
            && unit_en.async_serial_1_gate == $past(st.deep_sleep_clock_gate_1[ASYNC_1_BIT])
            && unit_en.async_serial_0_gate == $past(st.deep_sleep_clock_gate_1[ASYNC_0_BIT]);
    endproperty
    a_serial_bits: assert property (p_serial_bits) else $error("serial enables misplaced");

endmodule

// ===== tb/deep_sleep_clock_gating_one_tb.sv
`timescale 1ns/10ps
module deep_sleep_clock_gating_one_tb;
    import clock_gate_pkg::*;

    logic        sys_clk         = 1'b0;
    logic        rst             = 1'b1;
    reg_req_t    reg_req         = '0;
    logic [31:0] rdata;
    logic        sleep_mode      = 1'b0;
    logic        deep_sleep_mode = 1'b0;
    logic        periph_req;
    unit_gates_t periph_sel;
    logic        periph_ack;
    logic        bus_fault;
    unit_gates_t unit_en;
    logic        irq;
    logic        go              = 1'b0;
    unit_gates_t go_sel          = '0;
    int          num_errors      = 0;
    int          comparisons     = 0;
    int          bit_pos [8]     = '{COMPARATOR_BIT, GP_TIMER_2_BIT, GP_TIMER_1_BIT, GP_TIMER_0_BIT,
                                     TWO_WIRE_BIT, SYNC_SERIAL_BIT, ASYNC_1_BIT, ASYNC_0_BIT};

    always #2.5 sys_clk = ~sys_clk;

    deep_sleep_clock_gating_one DUT (
        .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .rdata(rdata),
        .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
        .periph_req(periph_req), .periph_sel(periph_sel), .periph_ack(periph_ack),
        .bus_fault(bus_fault), .unit_en(unit_en), .irq(irq)
    );

    periph_bus_model partner (
        .sys_clk(sys_clk), .rst(rst), .go(go), .go_sel(go_sel),
        .periph_req(periph_req), .periph_sel(periph_sel)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_req <= '0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_req <= '0;
        #1 q = rdata;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        chk(q, exp);
    endtask

    task automatic rmw(input logic [11:0] a, input logic [31:0] m);
        logic [31:0] q;
        rd(a, q);
        wr(a, q | m);
    endtask

    task automatic ue(input logic [7:0] exp);
        repeat (2) @(posedge sys_clk);
        #1 chk({24'h0, unit_en}, {24'h0, exp});
        @(posedge sys_clk);
    endtask

    task automatic irqc(input logic exp);
        #1 chk({31'h0, irq}, {31'h0, exp});
        @(posedge sys_clk);
    endtask

    task automatic acc(input unit_gates_t sel, input logic f);
        go     <= 1'b1;
        go_sel <= sel;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        #1 chk({30'h0, bus_fault, periph_ack}, f ? 32'h2 : 32'h1);
        @(posedge sys_clk);
    endtask

    task automatic stop_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdc(DEEP_CLOCK_GATE_1_OFS, 32'h0);
        ue(8'h00);
        irqc(1'b0);
        $display("test reset done");
        wr(DEEP_CLOCK_GATE_1_OFS, 32'hffff_ffff);
        rdc(DEEP_CLOCK_GATE_1_OFS, 32'h0107_1013);
        rdc(12'h128, 32'h0);
        $display("test access done");
        wr(RUN_CLOCK_CONFIG_OFS, 32'h0800_0000);
        deep_sleep_mode <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            wr(DEEP_CLOCK_GATE_1_OFS, 32'h1 << bit_pos[i]);
            ue(8'h80 >> i);
        end
        $display("test mapping done");
        wr(RUN_CLOCK_GATE_1_OFS, 32'h0);
        rmw(RUN_CLOCK_GATE_1_OFS, 32'h0100_0000);
        wr(SLEEP_CLOCK_GATE_1_OFS, 32'h10);
        wr(DEEP_CLOCK_GATE_1_OFS, 32'h1);
        wr(IRQ_STATUS_OFS, 32'h3);
        ue(8'h01);
        deep_sleep_mode <= 1'b0;
        sleep_mode      <= 1'b1;
        ue(8'h04);
        sleep_mode <= 1'b0;
        ue(8'h80);
        wr(RUN_CLOCK_CONFIG_OFS, 32'h0);
        deep_sleep_mode <= 1'b1;
        ue(8'h80);
        rdc(IRQ_STATUS_OFS, 32'h0);
        wr(RUN_CLOCK_CONFIG_OFS, 32'h0800_0000);
        ue(8'h01);
        deep_sleep_mode <= 1'b0;
        ue(8'h80);
        deep_sleep_mode <= 1'b1;
        ue(8'h01);
        rdc(IRQ_STATUS_OFS, 32'h2);
        wr(IRQ_STATUS_OFS, 32'h3);
        $display("test select done");
        acc(8'h01, 1'b0);
        acc(8'h80, 1'b1);
        wr(DEEP_CLOCK_GATE_1_OFS, 32'h0);
        ue(8'h00);
        for (int i = 0; i < 8; i++)
            acc(8'h80 >> i, 1'b1);
        rdc(FAULT_UNIT_OFS, 32'h01);
        rdc(IRQ_STATUS_OFS, 32'h1);
        irqc(1'b0);
        wr(IRQ_MASK_OFS, 32'h1);
        irqc(1'b1);
        wr(IRQ_STATUS_OFS, 32'h1);
        irqc(1'b0);
        rdc(IRQ_STATUS_OFS, 32'h0);
        go     <= 1'b1;
        go_sel <= 8'h80;
        @(posedge sys_clk);
        go <= 1'b0;
        wr(IRQ_STATUS_OFS, 32'h1);
        rdc(IRQ_STATUS_OFS, 32'h1);
        irqc(1'b1);
        $display("test fault done");
        wr(DEEP_CLOCK_GATE_1_OFS, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdc(DEEP_CLOCK_GATE_1_OFS, 32'h0);
        rdc(IRQ_STATUS_OFS, 32'h0);
        ue(8'h00);
        irqc(1'b0);
        $display("test reset again done");
        stop_test;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        stop_test;
    end
endmodule

// ===== tb/periph_bus_model.sv
`timescale 1ns/10ps
module periph_bus_model
    import clock_gate_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // command from the bench
    input  wire logic        go,
    input  wire unit_gates_t go_sel,
    // access toward the gated units
    output logic             periph_req,
    output unit_gates_t      periph_sel
);
    // ****************************************
    // one-cycle access; idle select toggles every cycle
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            periph_req <= 1'b0;
            periph_sel <= '0;
        end
        else
        begin
            periph_req <= go;
            periph_sel <= go ? go_sel : ~periph_sel;
        end
    end
endmodule
